// ==== pkg/spacing_if.sv ====
// Link between memory controller and memory device
`timescale 1ns/1ps
interface spacing_if;
   import spacing_pkg::*;
   cmd_type   cmd;
   logic      cke;
   logic      odt;
   logic      data_ok;
   logic      freq_change;
   logic      term_on;
   logic      data_corrupt;
   power_type power_state;
   modport ctrl (output cmd, output cke, output odt, output data_ok, output freq_change,
                 input term_on, input data_corrupt, input power_state);
   modport dram (input cmd, input cke, input odt, input data_ok, input freq_change,
                 output term_on, output data_corrupt, output power_state);
endinterface

// ==== pkg/spacing_params.svh ====
// Timing constants for the command spacing link
`ifndef SPACING_PARAMS_SVH
`define SPACING_PARAMS_SVH
`define CLK_PERIOD_PS      10000
`define PRECHARGE_PS       15000
`define WTR_MIN_CYCLES     2
`define CKE_HOLD_CYCLES    3
`define ODT_ON_CYCLES      2
`define ODT_OFF_CYCLES     2
`define PDX_CYCLES         2
`define WR_RESET           4'h4
`define CNT_W              5
`endif

// ==== pkg/spacing_pkg.sv ====
// Types shared by both ends of the command spacing link
package spacing_pkg;
   typedef enum logic [2:0] {
      cmd_nop   = 3'b000,
      cmd_act   = 3'b001,
      cmd_write = 3'b010,
      cmd_read  = 3'b011,
      cmd_wrap  = 3'b100,
      cmd_pre   = 3'b101
   } cmd_type;
   typedef enum logic [1:0] {
      pw_active = 2'b00,
      pw_pdown  = 2'b01,
      pw_sref   = 2'b10
   } power_type;
endpackage

// ==== rtl/ctrl_end.sv ====
// Controller end: command spacing counters and pin holds
`timescale 1ns/1ps
`include "spacing_params.svh"
// What this block and dram_end do
// RL1 - Auto-precharge delay is WR plus rounded precharge
// RL2 - Clock change only in self-refresh or power-down
// RL3 - Termination on two edges after control high
// RL4 - Termination off after second edge from low
// RL5 - Slow grades use 10ns on, 12.5ns off; dram_end uses 2 cycles (20ns) for both on and off
// RL6 - Write to read waits at least two cycles
// RL7 - Clock enable held three sampled edges
// RL8 - Rewrite location after bad write data timing
// RL9 - Time parameters become rounded-up cycle counts
// RL10 - Activate two edges after power-down exit
// RL11 - Down-counters block commands until zero
module ctrl_end
   import spacing_pkg::*;
#(
   parameter int WR_W = 4
)(
   input  wire logic            ref_clk,
   input  wire logic            rst_n,
   input  wire logic            clk_en,
   spacing_if.ctrl              link,
   input  wire logic [WR_W-1:0] wr_cycles,
   input  wire cmd_type         req_cmd,
   input  wire logic            req_valid,
   output logic                 req_ready,
   input  wire logic            req_data_ok,
   input  wire logic            req_cke,
   input  wire logic            req_odt,
   input  wire logic            req_freq,
   output logic                 freq_granted,
   output logic                 need_rewrite
);
   localparam int CW = `CNT_W;
   // Rounded-up precharge cycles
   localparam int PRE_CYC = (`PRECHARGE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;

   ////////////////////////////////////////////////////////////////////////////
   // How the spacing works, counter by counter
   //
   // Autoprecharge counter
   //   Loaded on the edge that takes a write with autoprecharge
   //   Value is write recovery plus the rounded-up precharge cycles
   //   Rounding up keeps the gap long enough at any clock period
   //   Activate stays refused until it has run down to zero
   //   Limitation: wr_cycles is read at the load edge only
   //
   // Write-to-read counter
   //   Loaded one above the minimum turnaround on every write
   //   The extra count covers the edge that registers the write itself
   //   Reads stay refused while it is nonzero
   //
   // Clock enable hold counter
   //   Loaded whenever the clock enable level moves
   //   Further moves wait until it is zero again
   //   So the device samples each level on three edges or more
   //   Trade-off: a quick wake-up request waits out a full hold
   //
   // Power-down exit counter
   //   Loaded when the clock enable rises
   //   Activate is refused until it has run down
   //
   // Rewrite flag
   //   Set by a write whose data timing was bad
   //   Cleared by the next write with good timing
   //   Reads stay refused while it is set; stale data is never trusted
   //
   // Frequency grant
   //   Only while the clock enable is low and settled
   //   Dropped on the same edge that starts a wake-up
   //   Hazard: a grant standing beside a high clock enable would let
   //   the clock move while the device is awake
   //
   // Clock enable input
   //   Low freezes every flip-flop of this end
   //   Counters then keep their values, so no gap is shortened
   //
   // Commands on the link stand one cycle, then fall back to nop

   logic [CW-1:0] dal_r, dal_nxt;
   logic [CW-1:0] wtr_r, wtr_nxt;
   logic [CW-1:0] cke_r, cke_nxt;
   logic [CW-1:0] pdx_r, pdx_nxt;
   logic          cke_o_r, cke_o_nxt;
   cmd_type       cmd_r,  cmd_nxt;
   logic          odt_r,  odt_nxt;
   logic          dok_r,  dok_nxt;
   logic          frq_r,  frq_nxt;
   logic          rew_r,  rew_nxt;
   logic          blocked;

   ////////////////////////////////////////////////////////////////////////////
   // Reads and activates each wait for their own counters; other commands wait only for the clock enable
   always_comb begin
      blocked = 1'b0;
      unique case (req_cmd)
         cmd_read:  blocked = (wtr_r != '0) || rew_r;      // [RL6] [RL8] [RL11]
         cmd_act:   blocked = (dal_r != '0) || (pdx_r != '0); // [RL10] [RL11]
         cmd_nop, cmd_write, cmd_wrap, cmd_pre: blocked = 1'b0;
      endcase
      if (!cke_o_r) blocked = 1'b1;
   end
   assign req_ready = !blocked;

   // Counter loads and countdown
   always_comb begin
      dal_nxt   = (dal_r != '0) ? dal_r - 1'b1 : dal_r;
      wtr_nxt   = (wtr_r != '0) ? wtr_r - 1'b1 : wtr_r;
      cke_nxt   = (cke_r != '0) ? cke_r - 1'b1 : cke_r;
      pdx_nxt   = (pdx_r != '0) ? pdx_r - 1'b1 : pdx_r;
      cke_o_nxt = cke_o_r;
      cmd_nxt   = cmd_nop;
      dok_nxt   = 1'b1;
      rew_nxt   = rew_r;
      odt_nxt   = req_odt;
      if (req_valid && !blocked) begin
         cmd_nxt = req_cmd;
         dok_nxt = req_data_ok;
         if (req_cmd == cmd_wrap) begin
            dal_nxt = CW'(wr_cycles) + CW'(PRE_CYC);       // [RL1] [RL9]
         end
         if (req_cmd == cmd_write || req_cmd == cmd_wrap) begin
            wtr_nxt = CW'(`WTR_MIN_CYCLES + 1);            // [RL6]
            rew_nxt = !req_data_ok;                        // [RL8]
         end
      end
      // Clock enable may only move after three sampled edges
      if (req_cke != cke_o_r && cke_r == '0) begin
         cke_o_nxt = req_cke;
         cke_nxt   = CW'(`CKE_HOLD_CYCLES);                // [RL7] [RL11]
         if (req_cke) pdx_nxt = CW'(`PDX_CYCLES);          // [RL10]
      end
   end

   // Frequency change is granted only while the clock enable is low
   // Next values are used so the grant drops on the wake-up edge itself
   always_comb begin
      frq_nxt = req_freq && !cke_o_r && !cke_o_nxt        // [RL2]
                && (cke_r == '0) && (cke_nxt == '0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Spacing counters; frozen with the rest while clk_en is low
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dal_r   <= '0;
         wtr_r   <= '0;
         cke_r   <= '0;
         pdx_r   <= '0;
      end else if (clk_en) begin
         dal_r   <= dal_nxt;
         wtr_r   <= wtr_nxt;
         cke_r   <= cke_nxt;
         pdx_r   <= pdx_nxt;
      end
   end

   // Clock enable level; high out of reset so the device starts awake
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cke_o_r <= 1'b1;
      end else if (clk_en) begin
         cke_o_r <= cke_o_nxt;
      end
   end

   // Command, termination and data timing toward the device
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_r   <= cmd_nop;
         odt_r   <= 1'b0;
         dok_r   <= 1'b1;
      end else if (clk_en) begin
         cmd_r   <= cmd_nxt;
         odt_r   <= odt_nxt;
         dok_r   <= dok_nxt;
      end
   end

   // Grant and rewrite flags
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         frq_r   <= 1'b0;
         rew_r   <= 1'b0;
      end else if (clk_en) begin
         frq_r   <= frq_nxt;
         rew_r   <= rew_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link pins and local status, all straight from flip-flops

   assign link.cmd         = cmd_r;
   assign link.cke         = cke_o_r;
   assign link.odt         = odt_r;
   assign link.data_ok     = dok_r;
   assign link.freq_change = frq_r;
   assign freq_granted     = frq_r;
   assign need_rewrite     = rew_r;
endmodule // ctrl_end

// ==== rtl/dram_end.sv ====
// Device end: termination timing and corruption tracking
`timescale 1ns/1ps
`include "spacing_params.svh"
module dram_end
   import spacing_pkg::*;
(
   input  wire logic  ref_clk,
   input  wire logic  rst_n,
   input  wire logic  clk_en,
   spacing_if.dram    link,
   output logic       term_active,
   output logic       corrupt_flag
);
   localparam int CW = `CNT_W;
   logic [CW-1:0] on_cnt_r,  on_cnt_nxt;
   logic [CW-1:0] off_cnt_r, off_cnt_nxt;
   logic          odt_q_r,   odt_q_nxt;
   logic          term_r,    term_nxt;
   logic          corr_r,    corr_nxt;
   power_type     pw_r,      pw_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Termination follows the registered control by counted edges
   always_comb begin
      on_cnt_nxt  = on_cnt_r;
      off_cnt_nxt = off_cnt_r;
      odt_q_nxt   = link.odt;
      term_nxt    = term_r;
      if (link.odt && !odt_q_r) begin
         on_cnt_nxt = CW'(`ODT_ON_CYCLES);                 // [RL3] [RL5] [RL9]
      end else if (on_cnt_r != '0) begin
         on_cnt_nxt = on_cnt_r - 1'b1;
         if (on_cnt_r == CW'(1)) term_nxt = 1'b1;
      end
      if (!link.odt && odt_q_r) begin
         off_cnt_nxt = CW'(`ODT_OFF_CYCLES);               // [RL4] [RL5] [RL9]
      end else if (off_cnt_r != '0) begin
         off_cnt_nxt = off_cnt_r - 1'b1;
         if (off_cnt_r == CW'(1)) term_nxt = 1'b0;
      end
   end

   // Corruption sticks until a clean write; each write sets or clears it by its data timing
   always_comb begin
      corr_nxt = corr_r;
      if (link.cmd == cmd_write || link.cmd == cmd_wrap) begin
         corr_nxt = !link.data_ok;                         // [RL8]
      end
      pw_nxt = pw_r;
      if (!link.cke) pw_nxt = (link.cmd == cmd_nop) ? pw_pdown : pw_sref;
      else pw_nxt = pw_active;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         on_cnt_r  <= '0;
         off_cnt_r <= '0;
         odt_q_r   <= 1'b0;
         term_r    <= 1'b0;
         corr_r    <= 1'b0;
         pw_r      <= pw_active;
      end else if (clk_en) begin
         on_cnt_r  <= on_cnt_nxt;
         off_cnt_r <= off_cnt_nxt;
         odt_q_r   <= odt_q_nxt;
         term_r    <= term_nxt;
         corr_r    <= corr_nxt;
         pw_r      <= pw_nxt;
      end
   end

   assign link.term_on      = term_r;
   assign link.data_corrupt = corr_r;
   assign link.power_state  = pw_r;
   assign term_active       = term_r;
   assign corrupt_flag      = corr_r;
endmodule // dram_end

// ==== testbench/ddr2_command_spacing_rules_tb_top.sv ====
// Bench driving both ends of the command spacing link
`timescale 1ns/1ps
`include "spacing_params.svh"
module ddr2_command_spacing_rules_tb_top
   import spacing_pkg::*;
;
   localparam int dal_cyc = 3 + (`PRECHARGE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
   logic       ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, req_valid = 1'b0, req_odt = 1'b0;
   logic       req_data_ok = 1'b1, req_cke = 1'b1, req_freq = 1'b0, req_ready, freq_granted;
   logic       need_rewrite, term_active, corrupt_flag;
   logic [3:0] wr_cycles = 4'h3; // Short recovery keeps the run brief
   cmd_type    req_cmd = cmd_nop;
   int         error_cnt = 0, cmp_count = 0, w;
   spacing_if  link ();
   always #5 ref_clk = ~ref_clk;
   ctrl_end u_ctrl_end (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .link(link.ctrl),
      .wr_cycles(wr_cycles), .req_cmd(req_cmd), .req_valid(req_valid), .req_ready(req_ready),
      .req_data_ok(req_data_ok), .req_cke(req_cke), .req_odt(req_odt), .req_freq(req_freq),
      .freq_granted(freq_granted), .need_rewrite(need_rewrite));
   dram_end u_dram_end (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .link(link.dram),
      .term_active(term_active), .corrupt_flag(corrupt_flag));
   spacing_link_sva u_spacing_link_sva (.ref_clk(ref_clk), .rst_n(rst_n), .cmd(link.cmd),
      .cke(link.cke), .odt(link.odt), .data_ok(link.data_ok), .freq_change(link.freq_change),
      .term_on(link.term_on), .data_corrupt(link.data_corrupt));
   ////////////////////////////////////////
   task automatic chk(input logic got, input logic exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Holds the request until taken; w counts refused cycles
   task automatic issue(input cmd_type c, output int w);
      @(negedge ref_clk);
      req_cmd = c;
      req_valid = 1'b1;
      for (w = 0; w < 40; w++) begin
         #1;
         if (req_ready === 1'b1) break;
         @(negedge ref_clk);
      end
      chk(w < 40, 1'b1, "stuck");
      if (w == 40) end_sim();
      @(negedge ref_clk);
      req_valid = 1'b0;
   endtask
   task automatic t_spacing();
      issue(cmd_write, w);
      chk(link.cmd === cmd_write, 1'b1, "write");
      issue(cmd_read, w);
      chk(w == 2, 1'b1, "read gap");
      issue(cmd_wrap, w);
      issue(cmd_act, w);
      chk(w + 2 >= dal_cyc && w + 2 <= dal_cyc + 1, 1'b1, "act gap");
   endtask
   // Bad write must block reads until rewritten
   task automatic t_bad();
      req_data_ok = 1'b0;
      issue(cmd_write, w);
      repeat (2) @(negedge ref_clk);
      chk(need_rewrite & corrupt_flag, 1'b1, "flag");
      req_cmd = cmd_read;
      req_valid = 1'b1;
      repeat (5) @(negedge ref_clk);
      chk(req_ready, 1'b0, "read taken");
      req_valid = 1'b0;
      req_data_ok = 1'b1;
      issue(cmd_write, w);
      repeat (2) @(negedge ref_clk);
      chk(need_rewrite | corrupt_flag, 1'b0, "clear");
   endtask
   // Clock enable low must freeze the spacing counters and the link
   task automatic t_freeze();
      issue(cmd_write, w);
      clk_en = 1'b0;
      @(negedge ref_clk);
      req_cmd = cmd_read;
      req_valid = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(link.cmd === cmd_write && req_ready === 1'b0, 1'b1, "frozen");
      req_valid = 1'b0;
      clk_en = 1'b1;
      issue(cmd_read, w);
      chk(w == 2, 1'b1, "freeze gap");
   endtask
   task automatic t_pins();
      req_odt = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk(term_active & link.term_on, 1'b1, "term on");
      req_odt = 1'b0;
      req_cke = 1'b0;
      req_freq = 1'b1;
      repeat (8) @(negedge ref_clk);
      chk(term_active | link.term_on, 1'b0, "term off");
      chk(freq_granted & link.freq_change & !link.cke, 1'b1, "freq");
      req_freq = 1'b0;
      repeat (2) @(negedge ref_clk);
      req_cke = 1'b1;
      issue(cmd_act, w);
      chk(w >= 1, 1'b1, "act exit");
   endtask
   initial begin
      repeat (16) @(negedge ref_clk);
      rst_n = 1'b1;
      t_spacing();
      t_bad();
      t_freeze();
      t_pins();
      end_sim();
   end
endmodule // ddr2_command_spacing_rules_tb_top

// ==== testbench/spacing_link_sva.sv ====
// Link assertions for the command spacing pair
`timescale 1ns/1ps
module spacing_link_sva
   import spacing_pkg::*;
(
   input wire logic    ref_clk,
   input wire logic    rst_n,
   input wire cmd_type cmd,
   input wire logic    cke,
   input wire logic    odt,
   input wire logic    data_ok,
   input wire logic    freq_change,
   input wire logic    term_on,
   input wire logic    data_corrupt
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   // Whole edges only; the half-period tail of turn-off is not modelled
   // The edge that registers odt counts as zero; the level flips on the second edge after it
   a_term_on_due: assert property ($rose(odt) ##1 odt ##1 odt |=> term_on)
      else $error("term on late");
   a_term_off_due: assert property ($fell(odt) ##1 !odt ##1 !odt |=> !term_on)
      else $error("term off late");
   a_corrupt_set: assert property (cmd == cmd_write && !data_ok |=> data_corrupt)
      else $error("bad write missed");
   a_corrupt_clear: assert property (cmd == cmd_write && data_ok |=> !data_corrupt)
      else $error("good write missed");
   a_read_gap: assert property (cmd == cmd_write |=> (cmd != cmd_read) [*2])
      else $error("read too soon");
   a_cke_hold: assert property ($changed(cke) |=> $stable(cke) [*2])
      else $error("cke hold short");
   a_act_exit: assert property ($rose(cke) |-> (cmd != cmd_act) [*2])
      else $error("act too soon");
   a_freq_safe: assert property (freq_change |-> !cke)
      else $error("clock change while active");
endmodule // spacing_link_sva
